//--- rtl/remote_speed_pkg.sv
// What this block does
// - Nonzero remote mode turns raise, lower, clear into setpoint controls only.
// - Mode 1 keeps speed always; mode 2 clears at power-up; mode 3 also at stop.
// - Run input drives motor toward main speed plus stored remote offset.
// - Raise ramps set speed up at the setpoint rise time rate.
// - Lower ramps set speed down at the setpoint fall time rate.
// - Clear discards the remote offset; main speed alone remains.
// - Main speed source is chosen by operating mode and terminal 4 select.
// - While run is on, operating speed follows set speed at run accel and decel rates; with run off it ramps to zero.
// - Remote offset is captured in captured_r when run is released; storage writes the minute sample.
// - With raise and lower idle, sample each minute; in mode 1 write memory if changed.
// - Periodic write decision ignores the clear input.
// - Remote offset is limited between zero and the top speed limit.
// - Modes 1 and 2 let raise and lower change speed without run.
// - Remote function is inhibited during jog or PID control.
// - Clear then power loss within a minute restores the old stored speed.
// - Remote function also works in network operating mode.
// - Ramp rate is reference speed divided by configured time.
// - Fall time value 9999 means use the rise time for falling.
//
// Purpose: constants and types for the remote speed setpoint unit
// Assumes: speeds in r/min, times in units of 0.1 s
// Notes:   one package shared by the design file and the verification files
package remote_speed_pkg;

  localparam int          SPEED_W        = 16;
  localparam int          TIME_W         = 16;
  localparam int          CLK_HZ         = 125_000_000;
  // Ramp step tick every 1 ms
  localparam int          STEP_MS        = 1;
  localparam int          STEP_CYCLES    = CLK_HZ / 1000 * STEP_MS;
  localparam int          STORE_MINUTE_S = 60;
  localparam int          STORE_TICKS    = STORE_MINUTE_S * 1000 / STEP_MS;
  localparam logic [TIME_W-1:0] TIME_SAME_AS_RISE = 16'h270f; // 9999
  localparam logic [SPEED_W-1:0] SPEED_ZERO       = 16'h0000;

  typedef enum logic [1:0] {
    REMOTE_OFF,
    REMOTE_STORED,
    REMOTE_HOLD_ONLY,
    REMOTE_VOLATILE
  } remote_mode_t;

  typedef enum logic [2:0] {
    OPMODE_EXTERNAL,
    OPMODE_PANEL,
    OPMODE_NETWORK,
    OPMODE_COMBINED_3,
    OPMODE_COMBINED_4
  } opmode_t;

  typedef struct packed {
    logic raise_request;
    logic lower_request;
    logic clear_request;
    logic forward_run;
    logic reverse_run;
    logic terminal4_select;
    logic jog_active;
    logic pid_active;
  } contacts_t;

  typedef struct packed {
    logic [TIME_W-1:0]  setpoint_rise_time;
    logic [TIME_W-1:0]  setpoint_fall_time;
    logic [TIME_W-1:0]  run_accel_time;
    logic [TIME_W-1:0]  run_decel_time;
    logic [SPEED_W-1:0] top_speed_limit;
    logic [SPEED_W-1:0] ramp_reference_speed;
  } ramp_cfg_t;

endpackage : remote_speed_pkg

//--- rtl/remote_speed_setpoint.sv
// Purpose: motorized-potentiometer speed setpoint with storage and run ramp
// Assumes: contact inputs asynchronous; nonvolatile store is a write port
// Notes:   ramps use a per-ms fractional accumulator; rate = ref*10/time
`timescale 1ns/100ps
`default_nettype none
module remote_speed_setpoint #(
  parameter int STEP_CYCLES_P = remote_speed_pkg::STEP_CYCLES,
  parameter int STORE_TICKS_P = remote_speed_pkg::STORE_TICKS
) (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 sys_rst_i,
  input  wire logic                                 clk_en_i,
  input  wire remote_speed_pkg::contacts_t          contacts_i,
  input  wire remote_speed_pkg::remote_mode_t       remote_function_mode_i,
  input  wire remote_speed_pkg::opmode_t            operating_mode_select_i,
  input  wire remote_speed_pkg::ramp_cfg_t          cfg_i,
  input  wire logic [remote_speed_pkg::SPEED_W-1:0] panel_unit_speed_i,
  input  wire logic [remote_speed_pkg::SPEED_W-1:0] terminal2_speed_i,
  input  wire logic [remote_speed_pkg::SPEED_W-1:0] terminal4_speed_i,
  input  wire logic [remote_speed_pkg::SPEED_W-1:0] nv_offset_i,
  output logic [remote_speed_pkg::SPEED_W-1:0]      set_speed_o,
  output logic [remote_speed_pkg::SPEED_W-1:0]      operating_speed_o,
  output logic                                      run_forward_o,
  output logic                                      run_reverse_o,
  output logic                                      multi_speed_enable_o,
  output logic [remote_speed_pkg::SPEED_W-1:0]      nv_write_data_o,
  output logic                                      nv_write_o
);
  import remote_speed_pkg::*;

  contacts_t          meta_r;
  contacts_t          sync_r;
  logic               boot_r;
  logic [31:0]        pre_r;
  logic               tick_r;
  logic [31:0]        minute_r;
  logic [SPEED_W-1:0] offset_r;
  logic [SPEED_W-1:0] main_r;
  logic [SPEED_W-1:0] oper_r;
  logic [31:0]        set_acc_r;
  logic [31:0]        run_acc_r;
  logic               run_d_r;
  logic [SPEED_W-1:0] sample_r;
  logic [SPEED_W-1:0] captured_r;
  logic               idle_d_r;

  logic               remote_on;
  logic               run_now;
  logic               adjust_ok;
  logic [SPEED_W-1:0] main_nxt;
  logic [TIME_W-1:0]  fall_time;
  logic [SPEED_W:0]   target;
  logic [SPEED_W-1:0] goal;
  logic [TIME_W-1:0]  run_tm;

  // Contacts are pins: two flops before use
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en_i) begin
      meta_r <= contacts_i;
      sync_r <= meta_r;
    end
  end

  assign remote_on = (remote_function_mode_i != REMOTE_OFF)
                     && !sync_r.jog_active && !sync_r.pid_active;
  assign run_now   = sync_r.forward_run || sync_r.reverse_run;
  assign adjust_ok = remote_on && (run_now
                     || remote_function_mode_i != REMOTE_VOLATILE);
  assign fall_time = (cfg_i.setpoint_fall_time == TIME_SAME_AS_RISE)
                     ? cfg_i.setpoint_rise_time : cfg_i.setpoint_fall_time;

  always_comb begin
    unique case (operating_mode_select_i)
      OPMODE_PANEL, OPMODE_NETWORK: main_nxt = panel_unit_speed_i;
      OPMODE_COMBINED_3: main_nxt = sync_r.terminal4_select ? terminal4_speed_i : SPEED_ZERO;
      OPMODE_EXTERNAL, OPMODE_COMBINED_4:
        main_nxt = sync_r.terminal4_select ? terminal4_speed_i : terminal2_speed_i;
      default: main_nxt = SPEED_ZERO;
    endcase
  end

  // Saturate main+offset into the speed width
  always_comb begin
    target = {1'b0, main_r} + {1'b0, offset_r};
    if (target[SPEED_W]) target = {1'b0, {SPEED_W{1'b1}}};
  end

  // Millisecond prescaler shared by ramps and minute timer
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end else if (clk_en_i) begin
      tick_r <= (pre_r == 32'(STEP_CYCLES_P - 1));
      pre_r  <= (pre_r == 32'(STEP_CYCLES_P - 1)) ? '0 : pre_r + 32'd1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) main_r <= '0;
    else if (clk_en_i) main_r <= main_nxt;
  end

  // Step a speed by 1 once the per-ms sums of ref*10 reach time_ds*1000; the step clears the fraction
  function automatic logic [31:0] acc_add(input logic [31:0] acc,
                                          input logic [SPEED_W-1:0] ref_spd);
    acc_add = acc + 32'(ref_spd) * 32'd10;
  endfunction : acc_add

  function automatic logic [31:0] acc_div(input logic [TIME_W-1:0] t);
    acc_div = (t == '0) ? 32'd1 : 32'(t) * 32'd1000;
  endfunction : acc_div

  // Remote offset: raise, lower, clear, mode revert, power-up restore
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      offset_r  <= '0;
      set_acc_r <= '0;
      boot_r    <= 1'b1;
    end else if (clk_en_i) begin
      boot_r <= 1'b0;
      if (boot_r) begin
        offset_r <= (remote_function_mode_i == REMOTE_STORED) ? nv_offset_i : SPEED_ZERO;
      end else if (!remote_on) begin
        set_acc_r <= '0;
      end else if (sync_r.clear_request) begin
        offset_r  <= SPEED_ZERO;
        set_acc_r <= '0;
      end else if (run_d_r && !run_now && remote_function_mode_i == REMOTE_VOLATILE) begin
        offset_r <= SPEED_ZERO;
      end else if (adjust_ok && tick_r && (sync_r.raise_request ^ sync_r.lower_request)) begin
        if (set_acc_r + 32'(cfg_i.ramp_reference_speed) * 32'd10
            >= acc_div(sync_r.raise_request ? cfg_i.setpoint_rise_time : fall_time)) begin
          set_acc_r <= '0;
          if (sync_r.raise_request) begin
            offset_r <= (offset_r >= cfg_i.top_speed_limit) ? cfg_i.top_speed_limit
                        : offset_r + 16'h0001;
          end else begin
            offset_r <= (offset_r == SPEED_ZERO) ? SPEED_ZERO : offset_r - 16'h0001;
          end
        end else begin
          set_acc_r <= acc_add(set_acc_r, cfg_i.ramp_reference_speed);
        end
      end
    end
  end

  always_comb begin
    goal   = run_now ? (remote_on ? target[SPEED_W-1:0] : main_r) : SPEED_ZERO;
    run_tm = (goal > oper_r) ? cfg_i.run_accel_time : cfg_i.run_decel_time;
  end

  // Operating speed ramps toward set speed while running
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oper_r    <= '0;
      run_acc_r <= '0;
    end else if (clk_en_i && tick_r) begin
      if (goal == oper_r) begin
        run_acc_r <= '0;
      end else if (run_acc_r + 32'(cfg_i.ramp_reference_speed) * 32'd10 >= acc_div(run_tm)) begin
        run_acc_r <= '0;
        oper_r    <= (goal > oper_r) ? oper_r + 16'h0001 : oper_r - 16'h0001;
      end else begin
        run_acc_r <= acc_add(run_acc_r, cfg_i.ramp_reference_speed);
      end
    end
  end

  // Storage: capture at run release, minute compare-and-write once idle
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_d_r    <= 1'b0;
      idle_d_r   <= 1'b1;
      minute_r   <= '0;
      sample_r   <= '0;
      captured_r <= '0;
      nv_write_o <= 1'b0;
      nv_write_data_o <= '0;
    end else if (clk_en_i) begin
      run_d_r    <= run_now;
      idle_d_r   <= !(sync_r.raise_request || sync_r.lower_request);
      nv_write_o <= 1'b0;
      if (run_d_r && !run_now) captured_r <= offset_r;
      // Sample starts as the restored word, else a clear to zero is never written
      if (boot_r) begin
        sample_r <= (remote_function_mode_i == REMOTE_STORED) ? nv_offset_i : SPEED_ZERO;
      end else if (sync_r.raise_request || sync_r.lower_request || !idle_d_r) begin
        minute_r <= '0;
      end else if (tick_r) begin
        if (minute_r == 32'(STORE_TICKS_P - 1)) begin
          minute_r <= '0;
          sample_r <= offset_r;
          if (offset_r != sample_r && remote_function_mode_i == REMOTE_STORED) begin
            nv_write_o      <= 1'b1;
            nv_write_data_o <= offset_r;
          end
        end else begin
          minute_r <= minute_r + 32'd1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      set_speed_o          <= '0;
      operating_speed_o    <= '0;
      run_forward_o        <= 1'b0;
      run_reverse_o        <= 1'b0;
      multi_speed_enable_o <= 1'b1;
    end else if (clk_en_i) begin
      set_speed_o          <= remote_on ? target[SPEED_W-1:0] : main_r;
      operating_speed_o    <= oper_r;
      run_forward_o        <= sync_r.forward_run;
      run_reverse_o        <= sync_r.reverse_run && !sync_r.forward_run;
      multi_speed_enable_o <= (remote_function_mode_i == REMOTE_OFF);
    end
  end

  AST_OFFSET_LIMIT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && !boot_r && offset_r <= cfg_i.top_speed_limit
      |=> offset_r <= cfg_i.top_speed_limit || $changed(cfg_i.top_speed_limit))
    else $error("Offset above limit");
  AST_CLEAR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && !boot_r && remote_on && sync_r.clear_request |=> offset_r == SPEED_ZERO)
    else $error("Clear did not zero offset");
  AST_MULTI: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && remote_function_mode_i != REMOTE_OFF |=> !multi_speed_enable_o)
    else $error("Multi-speed enabled in remote mode");
  AST_INHIBIT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && !boot_r && (sync_r.jog_active || sync_r.pid_active) |=> $stable(offset_r))
    else $error("Offset moved during jog or PID");
  AST_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && run_d_r && !run_now |=> captured_r == $past(offset_r))
    else $error("Run release not captured");
  AST_WRITE_CHANGED: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(nv_write_o) |-> nv_write_data_o == sample_r && nv_write_data_o != $past(sample_r))
    else $error("Write without change");
  AST_WRITE_IDLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(nv_write_o) |-> $past(!sync_r.raise_request && !sync_r.lower_request))
    else $error("Write while adjusting");
  AST_VOLATILE_STOP: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    clk_en_i && !boot_r && remote_on && run_d_r && !run_now
      && remote_function_mode_i == REMOTE_VOLATILE |=> offset_r == SPEED_ZERO)
    else $error("Mode 3 kept offset after stop");

endmodule : remote_speed_setpoint
`default_nettype wire

//--- verification/contact_panel_model.sv
// Purpose: far side of the setpoint unit: switch contacts and the value store
// Assumes: the bench sets the switch levels at the falling clock edge
// Notes:   the store keeps its word through reset, like a power cycle
`timescale 1ns/100ps
`default_nettype none
module contact_panel_model (
  input  wire logic                                 sys_clk_i,
  input  wire remote_speed_pkg::contacts_t          switches_i,
  input  wire logic                                 nv_write_i,
  input  wire logic [remote_speed_pkg::SPEED_W-1:0] nv_write_data_i,
  output var remote_speed_pkg::contacts_t           contacts_o,
  output logic [remote_speed_pkg::SPEED_W-1:0]      nv_offset_o,
  output logic [7:0]                                nv_writes_o
);
  import remote_speed_pkg::*;
  logic [SPEED_W-1:0] store_r  = 16'h0000;
  logic [7:0]         writes_r = 8'h00;
  assign contacts_o  = switches_i;
  assign nv_offset_o = store_r;
  assign nv_writes_o = writes_r;
  // Old word survives until a write lands, so a late clear is lost
  always @(posedge sys_clk_i) begin
    if (nv_write_i) begin
      store_r  <= nv_write_data_i;
      writes_r <= writes_r + 8'h01;
    end
  end
endmodule : contact_panel_model
`default_nettype wire

//--- verification/remote_speed_setpoint_tb.sv
// Purpose: self-checking bench for the remote speed setpoint unit
// Assumes: 4 cycles a tick, 5 ticks a store interval
// Notes:   ramp times 0 so a tick moves 1 r/min; fall 9999 borrows rise
`timescale 1ns/100ps
`default_nettype none
module remote_speed_setpoint_tb;
  import remote_speed_pkg::*;
  localparam contacts_t RAISE = 8'h80;
  localparam contacts_t LOWER = 8'h40;
  localparam contacts_t CLEAR = 8'h20;
  localparam contacts_t FWD   = 8'h10;
  localparam contacts_t REV   = 8'h08;
  localparam contacts_t T4SEL = 8'h04;
  logic               sys_clk;
  logic               sys_rst;
  logic               clk_en;
  contacts_t          sw;
  contacts_t          contacts;
  remote_mode_t       mode;
  opmode_t            opm;
  ramp_cfg_t          cfg;
  logic [SPEED_W-1:0] pnl, t2, t4, nv_off, set_spd, op_spd, nv_data;
  logic               run_f, run_r, multi, nv_wr;
  logic [7:0]         nv_cnt;
  int                 mismatches = 0;
  int                 num_checks = 0;
  int                 cycles = 0;

  remote_speed_setpoint #(.STEP_CYCLES_P(4), .STORE_TICKS_P(5)) remote_speed_setpoint_i (
    .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .clk_en_i(clk_en), .contacts_i(contacts),
    .remote_function_mode_i(mode), .operating_mode_select_i(opm), .cfg_i(cfg),
    .panel_unit_speed_i(pnl), .terminal2_speed_i(t2), .terminal4_speed_i(t4),
    .nv_offset_i(nv_off), .set_speed_o(set_spd), .operating_speed_o(op_spd),
    .run_forward_o(run_f), .run_reverse_o(run_r), .multi_speed_enable_o(multi),
    .nv_write_data_o(nv_data), .nv_write_o(nv_wr));
  contact_panel_model contact_panel_model_i (
    .sys_clk_i(sys_clk), .switches_i(sw), .nv_write_i(nv_wr), .nv_write_data_i(nv_data),
    .contacts_o(contacts), .nv_offset_o(nv_off), .nv_writes_o(nv_cnt));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : settle
  // Bounded wait; the value is judged even if the limit runs out
  task automatic soon(input string what, input logic [15:0] exp, ref logic [15:0] sig);
    for (int i = 0; i < 800 && sig !== exp; i++) @(negedge sys_clk);
    check(what, exp, sig);
  endtask : soon
  task automatic power_up(input remote_mode_t m);
    sys_rst = 1'b1;
    sw      = '0;
    mode    = m;
    settle(20);
    sys_rst = 1'b0;
    settle(6);
  endtask : power_up
  task automatic s_flags();
    check("multi_speed_after_reset", 16'h0001, {15'h0000, multi});
    power_up(REMOTE_STORED);
    check("multi_speed_remote", 16'h0000, {15'h0000, multi});
  endtask : s_flags
  task automatic s_main();
    logic [15:0] exp;
    power_up(REMOTE_OFF);
    for (int k = 0; k < 6; k++) begin
      opm = (k == 5) ? OPMODE_COMBINED_3 : opmode_t'(3'(k));
      sw  = (k == 5) ? T4SEL : '0;
      exp = (k == 0 || k == 4) ? t2 : (k == 1 || k == 2) ? pnl : (k == 5) ? t4 : 16'h0000;
      settle(6);
      check("main_speed", exp, set_spd);
    end
    sw  = '0;
    opm = OPMODE_NETWORK;
  endtask : s_main
  task automatic s_ramp();
    logic [7:0] n;
    power_up(REMOTE_STORED);
    sw = RAISE;
    soon("raise_to_limit", 16'h006e, set_spd);
    settle(40);
    check("raise_clamped", 16'h006e, set_spd);
    sw = '0;
    soon("store_after_raise", 16'h000a, nv_off);
    settle(2);
    n = nv_cnt;
    settle(60);
    check("no_rewrite_unchanged", {8'h00, n}, {8'h00, nv_cnt});
    sw = LOWER;
    soon("lower_to_main", 16'h0064, set_spd);
    settle(40);
    check("lower_floor", 16'h0064, set_spd);
    sw = RAISE;
    soon("raise_again", 16'h006e, set_spd);
    sw = CLEAR;
    soon("clear_to_main", 16'h0064, set_spd);
    soon("store_while_clear", 16'h0000, nv_off);
  endtask : s_ramp
  task automatic s_power();
    sw = RAISE;
    soon("raise_before_loss", 16'h006e, set_spd);
    sw = '0;
    soon("stored_before_loss", 16'h000a, nv_off);
    sw = CLEAR;
    settle(6);
    power_up(REMOTE_STORED);
    check("restore_after_early_loss", 16'h006e, set_spd);
    sw = CLEAR;
    soon("store_cleared_word", 16'h0000, nv_off);
    power_up(REMOTE_STORED);
    check("restore_after_late_loss", 16'h0064, set_spd);
    power_up(REMOTE_HOLD_ONLY);
    check("mode2_power_clears", 16'h0064, set_spd);
    sw = RAISE;
    soon("mode2_raise_no_run", 16'h006e, set_spd);
    sw = FWD;
    settle(6);
    sw = '0;
    settle(6);
    check("mode2_stop_holds", 16'h006e, set_spd);
  endtask : s_power
  task automatic s_run();
    // Volatile mode suits frequent start toggling
    power_up(REMOTE_VOLATILE);
    sw = RAISE;
    settle(60);
    check("mode3_raise_no_run", 16'h0064, set_spd);
    sw = contacts_t'(RAISE | FWD);
    soon("raise_while_run", 16'h006e, set_spd);
    check("run_forward", 16'h0001, {15'h0000, run_f});
    soon("operating_reaches_set", 16'h006e, op_spd);
    sw = '0;
    soon("mode3_stop_clears", 16'h0064, set_spd);
    soon("operating_to_zero", 16'h0000, op_spd);
    sw = REV;
    settle(6);
    check("run_reverse", 16'h0001, {15'h0000, run_r});
    sw = '0;
  endtask : s_run
  task automatic s_inhibit();
    power_up(REMOTE_STORED);
    for (int k = 0; k < 2; k++) begin
      sw = contacts_t'(RAISE | (k == 0 ? 8'h02 : 8'h01));
      settle(60);
      check("inhibit_jog_pid", 16'h0064, set_spd);
    end
    // Enable low must freeze the ramp
    clk_en = 1'b0;
    sw     = RAISE;
    settle(60);
    check("freeze_clk_en", 16'h0064, set_spd);
    clk_en = 1'b1;
    soon("thaw_raise", 16'h006e, set_spd);
    sw = '0;
  endtask : s_inhibit
  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    clk_en = 1'b1;
    pnl = 16'h0064;
    t2  = 16'h00c8;
    t4  = 16'h012c;
    opm = OPMODE_PANEL;
    cfg = '{16'h0000, 16'h270f, 16'h0000, 16'h0000, 16'h000a, 16'h0bb8};
    power_up(REMOTE_OFF);
    s_flags();
    s_main();
    s_ramp();
    s_power();
    s_run();
    s_inhibit();
    give_verdict();
  end
endmodule : remote_speed_setpoint_tb
`default_nettype wire
